// ### pis_chk.sv
// Checker for the interrupt source block: request causes, flags and tick spacing.
// Assumes it is bound to pis_top and sees only that module's ports.
`timescale 1ns/100ps
module pis_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  cap_a_edge_en,
  input wire logic [1:0]  cap_b_edge_en,
  input wire logic        spi_last_edge,
  input wire logic [2:0]  ep_data_written,
  input wire logic [2:0]  ep_ack_out_mode,
  input wire logic [2:0]  ep_nak_stall,
  input wire logic [2:0]  ep_in_acked,
  input wire logic        ctl_setup_mode,
  input wire logic        ctl_zlp_sent,
  input wire logic        transfer_complete_flag,
  input wire logic [10:0] irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  logic [31:0] g1_q, g1_d, g2_q, g2_d;
  logic        s1_q, s1_d, s2_q, s2_d;
  // Cycles since each timer's last tick.
  always_comb begin
    g1_d = irq_req[1] ? '0 : g1_q + 32'h0000_0001;
    g2_d = irq_req[2] ? '0 : g2_q + 32'h0000_0001;
    s1_d = s1_q | irq_req[1];
    s2_d = s2_q | irq_req[2];
  end
  // Registers the tick counters.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {g1_q, g2_q, s1_q, s2_q} <= '0;
    end else begin
      {g1_q, g2_q, s1_q, s2_q} <= {g1_d, g2_d, s1_d, s2_d};
    end
  end
  ////////////////////////////////////////
  // A cycle with no control endpoint event at all.
  sequence ep0_idle_s;
    !(ep_data_written[0] | ep_ack_out_mode[0] | ep_nak_stall[0] | ep_in_acked[0] |
      ctl_setup_mode | ctl_zlp_sent);
  endsequence
  spi_flag_a: assert property (spi_last_edge |=> transfer_complete_flag)
    else $error("Done flag not set after the last bit edge.");
  flag_sticky_a: assert property (transfer_complete_flag |=> transfer_complete_flag)
    else $error("Done flag dropped without reset.");
  spi_cause_a: assert property (irq_req[6] |-> $past(spi_last_edge))
    else $error("Serial request without a last bit edge.");
  ep0_cause_a: assert property (not (ep0_idle_s ##1 irq_req[3]))
    else $error("Control endpoint request without a cause.");
  ep1_cause_a: assert property (irq_req[4] |-> $past(ep_data_written[1] |
    ep_ack_out_mode[1] | ep_nak_stall[1] | ep_in_acked[1]))
    else $error("First data endpoint request without a cause.");
  ep2_cause_a: assert property (irq_req[5] |-> $past(ep_data_written[2] |
    ep_ack_out_mode[2] | ep_nak_stall[2] | ep_in_acked[2]))
    else $error("Second data endpoint request without a cause.");
  cap_a_edge_a: assert property (irq_req[7] |-> $past(cap_a_edge_en) != 2'h0)
    else $error("Capture A request with no edge enabled.");
  cap_b_edge_a: assert property (irq_req[8] |-> $past(cap_b_edge_en) != 2'h0)
    else $error("Capture B request with no edge enabled.");
  tick_gap_a: assert property (irq_req[1] && s1_q |-> (g1_q + 1) % 5120 == 0)
    else $error("Short tick off its period.");
  ms_gap_a: assert property (irq_req[2] && s2_q |-> (g2_q + 1) % 40960 == 0)
    else $error("Long tick off its period.");
endmodule // pis_chk

bind pis_top pis_chk u_chk (.*);

// ### pis_cpu_model.sv
// CPU side model: takes each request pulse and keeps counts and spacing per source.
// Assumes request pulses are one cycle wide on aclk.
`timescale 1ns/100ps
module pis_cpu_model (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [10:0] irq_req
);
  int cyc = 0;
  int cnt  [11];
  int last [11];
  int gap  [11];
  // Endpoint requests are only counted here; payload checks stay with firmware.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    for (int b = 0; b < 11; b++) begin
      if (!aresetn) begin
        cnt[b] <= 0;
      end else if (irq_req[b] === 1'b1) begin
        cnt[b]  <= cnt[b] + 1;
        gap[b]  <= cyc - last[b];
        last[b] <= cyc;
      end
    end
  end
endmodule // pis_cpu_model

// ### pis_pkg.sv
// Package for the peripheral interrupt source block: register map, fields, timing.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package pis_pkg;

  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0] IDX_P0_EN    = 8'h04;
  localparam logic [7:0] IDX_P1_EN    = 8'h05;
  localparam logic [7:0] IDX_P0_POL   = 8'h06;
  localparam logic [7:0] IDX_P1_POL   = 8'h07;
  localparam logic [7:0] IDX_GLB_EN   = 8'h20;
  localparam logic [7:0] IDX_EP_EN    = 8'h21;
  localparam logic [7:0] IDX_USB_CTL  = 8'h30;
  localparam logic [7:0] IDX_STATUS   = 8'h31;

  // Global enable bit positions.
  localparam int BIT_BUS   = 0;
  localparam int BIT_T128  = 1;
  localparam int BIT_T1024 = 2;
  localparam int BIT_SPI   = 3;
  localparam int BIT_CAPA  = 4;
  localparam int BIT_CAPB  = 5;
  localparam int BIT_GPIO  = 6;

  // Bus-event mode bit in the USB control register.
  localparam int BIT_PS2_MODE = 0;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Timing.
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_US       = 128;
  localparam int TICK_CYC      = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int MS_TICKS      = 8;
  localparam int BUS_QUAL_US   = 256;
  localparam int BUS_QUAL_TCK  = BUS_QUAL_US / TICK_US;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pis_pkg

// ### pis_top.sv
// Interrupt source logic: timer ticks, bus-event detector, SPI, capture,
// endpoint and GPIO requests, gated by enables and handed to the CPU.
// Assumes pins are asynchronous and endpoint and SPI events are one-cycle
// pulses from logic on aclk.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: Capture pins A and B each interrupt on enabled rising or falling edges.
// R2: SPI request is raised at the last bit edge; done flag reads high.
// R3: Enabled periodic tick every 1.024 ms from the free-running timer.
// R4: Enabled periodic tick every 128 us from the same timer.
// R5: Firmware should clear both tick enables before suspend.
// R6: Bus-event source picks USB reset or PS/2 activity by a mode bit.
// R7: Bus condition qualifies after 256 us, possibly after only 128 us.
// R8: USB mode: qualified SE0 raises the request when SE0 ends.
// R9: PS/2 mode: qualified long low on data raises the request at once.
// R10: Device address is held cleared while a bus event is qualified.
// R11: Request may come up to 128 us after the condition goes away.
// R12: Endpoint enable register: bits 2..0 read/write, rest zero, reset zero.
// R13: Data endpoints interrupt on valid data, or any data in ACK-OUT modes.
// R14: Data endpoints interrupt on NAK/STALL to IN or OUT, and IN ACK.
// R15: Control endpoint interrupts on SETUP-accept mode and zero-length status.
// R16: Control endpoint interrupts on data writes and NAK/STALL answers.
// R17: Firmware must check endpoint data validity itself.
// R18: Write-only per-pin GPIO enables for both ports, reset zero.
// R19: Port 0 polarity bits: 1 rising, 0 falling, write-only, reset zero.
// R20: Port 1 polarity register, same meaning, write-only, reset zero.
// R21: After one pin triggers, others are blocked until it idles or is disabled.
// R22: Global enable bits: bus, 128us, 1.024ms, SPI, capture A, B.
// R23: Requests reach the CPU only while the source enable is set.
module pis_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_zero_pins,
  input  wire logic [7:0]  port_one_pins,
  input  wire logic        cap_a_pin,
  input  wire logic        cap_b_pin,
  input  wire logic [1:0]  cap_a_edge_en,
  input  wire logic [1:0]  cap_b_edge_en,
  input  wire logic        usb_dp,
  input  wire logic        usb_dm,
  input  wire logic        ps2_data_pin,
  input  wire logic        spi_last_edge,
  input  wire logic [2:0]  ep_data_written,
  input  wire logic [2:0]  ep_ack_out_mode,
  input  wire logic [2:0]  ep_nak_stall,
  input  wire logic [2:0]  ep_in_acked,
  input  wire logic        ctl_setup_mode,
  input  wire logic        ctl_zlp_sent,
  output logic             transfer_complete_flag,
  output logic             dev_addr_clear,
  output logic [10:0]      irq_req
);

  //////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers for all pins.
  localparam int NPIN = 21;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q;
  logic [NPIN-1:0] stab_q, stab_d, stab_prev_q;

  assign pin_raw = {ps2_data_pin, usb_dm, usb_dp, cap_b_pin, cap_a_pin,
                    port_one_pins, port_zero_pins};

  // A change counts once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      stab_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stab_q[i];
    end
  end

  // Synchroniser registers; reset to idle-high pin levels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q        <= '1;
      s2_q        <= '1;
      s3_q        <= '1;
      stab_q      <= '1;
      stab_prev_q <= '1;
    end else begin
      s1_q        <= pin_raw;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      stab_q      <= stab_d;
      stab_prev_q <= stab_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] p0_en_q, p0_en_d, p1_en_q, p1_en_d;
  logic [7:0] p0_pol_q, p0_pol_d, p1_pol_q, p1_pol_d;
  logic [7:0] glb_en_q, glb_en_d, ep_en_q, ep_en_d, usb_ctl_q, usb_ctl_d;

  // AXI write and read channel state.
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
  logic [7:0]  awidx_q, awidx_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  // Word index from a byte address; anything above 0x3FF or not word-aligned is unmapped.
  function automatic logic [8:0] addr_idx(input logic [31:0] a);
    addr_idx = (a[31:10] == '0 && a[1:0] == 2'b00) ? {1'b1, a[9:2]} : 9'h000;
  endfunction

  // Whether an index names a register that exists.
  function automatic logic idx_ok(input logic [7:0] idx);
    idx_ok = idx inside {pis_pkg::IDX_P0_EN, pis_pkg::IDX_P1_EN, pis_pkg::IDX_P0_POL,
                         pis_pkg::IDX_P1_POL, pis_pkg::IDX_GLB_EN, pis_pkg::IDX_EP_EN,
                         pis_pkg::IDX_USB_CTL, pis_pkg::IDX_STATUS};
  endfunction

  logic [8:0] aw_dec, ar_dec;
  logic       do_write;
  logic [7:0] req_stat;

  // Write path: accept address and data in either order, respond after both.
  always_comb begin
    aw_dec    = addr_idx(s_axi_awaddr);
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awidx_d   = awidx_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_write  = 1'b0;
    p0_en_d   = p0_en_q;
    p1_en_d   = p1_en_q;
    p0_pol_d  = p0_pol_q;
    p1_pol_d  = p1_pol_q;
    glb_en_d  = glb_en_q;
    ep_en_d   = ep_en_q;
    usb_ctl_d = usb_ctl_q;
    if (s_axi_awvalid && !aw_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b1;
      awidx_d   = aw_dec[8] ? aw_dec[7:0] : 8'hFF;
    end
    if (s_axi_wvalid && !w_hold_q && !bvalid_q) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      do_write  = 1'b1;
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = idx_ok(awidx_q) ? pis_pkg::RESP_OKAY : pis_pkg::RESP_SLVERR;
    end
    if (do_write && wstrb0_q) begin
      unique case (awidx_q)
        pis_pkg::IDX_P0_EN:   p0_en_d   = wdata_q[7:0];                // R18
        pis_pkg::IDX_P1_EN:   p1_en_d   = wdata_q[7:0];                // R18
        pis_pkg::IDX_P0_POL:  p0_pol_d  = wdata_q[7:0];                // R19
        pis_pkg::IDX_P1_POL:  p1_pol_d  = wdata_q[7:0];                // R20
        pis_pkg::IDX_GLB_EN:  glb_en_d  = wdata_q[7:0];                // R22
        pis_pkg::IDX_EP_EN:   ep_en_d   = {5'b00000, wdata_q[2:0]};    // R12
        pis_pkg::IDX_USB_CTL: usb_ctl_d = {7'b0000000, wdata_q[0]};
        default: ;
      endcase
    end
  end

  // Read path: one-cycle answer; write-only registers read zero.
  always_comb begin
    ar_dec   = addr_idx(s_axi_araddr);
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d  = '0;
      rresp_d  = (ar_dec[8] && idx_ok(ar_dec[7:0])) ? pis_pkg::RESP_OKAY
                                                     : pis_pkg::RESP_SLVERR;
      if (ar_dec[8]) begin
        unique case (ar_dec[7:0])
          pis_pkg::IDX_GLB_EN:  rdata_d = {24'h00_0000, glb_en_q};
          pis_pkg::IDX_EP_EN:   rdata_d = {24'h00_0000, ep_en_q};          // R12
          pis_pkg::IDX_USB_CTL: rdata_d = {24'h00_0000, usb_ctl_q};
          pis_pkg::IDX_STATUS:  rdata_d = {24'h00_0000, req_stat};
          default:              rdata_d = '0;
        endcase
      end
    end
  end

  // Register bank and bus state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p0_en_q   <= pis_pkg::RST_BYTE;
      p1_en_q   <= pis_pkg::RST_BYTE;
      p0_pol_q  <= pis_pkg::RST_BYTE;
      p1_pol_q  <= pis_pkg::RST_BYTE;
      glb_en_q  <= pis_pkg::RST_BYTE;
      ep_en_q   <= pis_pkg::RST_BYTE;
      usb_ctl_q <= pis_pkg::RST_BYTE;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awidx_q   <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= pis_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= pis_pkg::RESP_OKAY;
    end else begin
      p0_en_q   <= p0_en_d;
      p1_en_q   <= p1_en_d;
      p0_pol_q  <= p0_pol_d;
      p1_pol_q  <= p1_pol_d;
      glb_en_q  <= glb_en_d;
      ep_en_q   <= ep_en_d;
      usb_ctl_q <= usb_ctl_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awidx_q   <= awidx_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Free-running timer: 128 us prescaler and 1.024 ms divider.
  logic [12:0] pre_q, pre_d;
  logic [2:0]  ms_q, ms_d;
  logic        tick128, tick1024;

  // Prescaler wraps every 128 us; eight of those give 1.024 ms.
  always_comb begin
    tick128  = (pre_q == 13'(pis_pkg::TICK_CYC - 1));
    pre_d    = tick128 ? '0 : pre_q + 13'd1;
    tick1024 = tick128 && (ms_q == 3'(pis_pkg::MS_TICKS - 1));
    ms_d     = tick128 ? ms_q + 3'd1 : ms_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus-event detector, sampled at 128 us granularity.
  typedef enum logic [1:0] {BUS_IDLE, BUS_SEEN, BUS_QUAL} pis_bus_t;
  pis_bus_t   bus_q, bus_d;
  logic [1:0] bus_cnt_q, bus_cnt_d;
  logic       cond, bus_ev, ps2_mode;

  // Condition follows the mode bit: SE0 on D+/D- or a low PS/2 data line.
  always_comb begin
    ps2_mode  = usb_ctl_q[pis_pkg::BIT_PS2_MODE];                   // R6
    cond      = ps2_mode ? !stab_q[20] : (!stab_q[18] && !stab_q[19]);
    bus_d     = bus_q;
    bus_cnt_d = bus_cnt_q;
    bus_ev    = 1'b0;
    if (tick128) begin
      unique case (bus_q)
        BUS_IDLE: begin
          bus_cnt_d = '0;
          if (cond) begin
            bus_d = BUS_SEEN;
          end
        end
        BUS_SEEN: begin
          if (!cond) begin
            bus_d = BUS_IDLE;
          end else if (bus_cnt_q == 2'(pis_pkg::BUS_QUAL_TCK - 2)) begin
            bus_d  = BUS_QUAL;                                      // R7
            bus_ev = ps2_mode;                                      // R9
          end else begin
            bus_cnt_d = bus_cnt_q + 2'd1;
          end
        end
        BUS_QUAL: begin
          if (!cond) begin
            bus_d  = BUS_IDLE;
            bus_ev = !ps2_mode;                                     // R8 R11
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge sources: capture pins and GPIO with the one-pin lockout.
  logic [15:0] gp_now, gp_prev, gp_trig, gp_active, gp_en, gp_pol;
  logic        gp_lock_q, gp_lock_d;
  logic [3:0]  gp_who_q, gp_who_d;
  logic        gp_ev, cap_a_ev, cap_b_ev;

  // Enabled edge per pin, chosen by its polarity bit.
  always_comb begin
    gp_now    = stab_q[15:0];
    gp_prev   = stab_prev_q[15:0];
    gp_en     = {p1_en_q, p0_en_q};
    gp_pol    = {p1_pol_q, p0_pol_q};
    for (int i = 0; i < 16; i++) begin
      gp_active[i] = (gp_pol[i] ? gp_now[i] : !gp_now[i]);             // R19 R20
      gp_trig[i]   = gp_en[i] && gp_active[i]                           // R18
                     && (gp_now[i] != gp_prev[i]);
    end
    gp_lock_d = gp_lock_q;
    gp_who_d  = gp_who_q;
    gp_ev     = 1'b0;
    if (gp_lock_q) begin
      if (!gp_active[gp_who_q] || !gp_en[gp_who_q]) begin
        gp_lock_d = 1'b0;                                           // R21
      end
    end else begin
      for (int i = 15; i >= 0; i--) begin
        if (gp_trig[i]) begin
          gp_who_d = 4'(i);
        end
      end
      if (gp_trig != '0) begin
        gp_ev     = 1'b1;
        gp_lock_d = 1'b1;                                           // R21
      end
    end
    cap_a_ev = (cap_a_edge_en[0] && stab_q[16] && !stab_prev_q[16])   // R1
            || (cap_a_edge_en[1] && !stab_q[16] && stab_prev_q[16]);
    cap_b_ev = (cap_b_edge_en[0] && stab_q[17] && !stab_prev_q[17])   // R1
            || (cap_b_edge_en[1] && !stab_q[17] && stab_prev_q[17]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request gating toward the CPU and state registers.
  logic [10:0] req_d;
  logic [2:0]  ep_ev;
  logic        tcf_d;

  // Endpoint events and enable gating; vector order 1..10 maps to bits 0..9.
  always_comb begin
    ep_ev[0] = ctl_setup_mode || ctl_zlp_sent                       // R15
            || ep_data_written[0] || ep_ack_out_mode[0] || ep_nak_stall[0];  // R16
    for (int e = 1; e < 3; e++) begin
      ep_ev[e] = ep_data_written[e] || ep_ack_out_mode[e]          // R13
              || ep_nak_stall[e] || ep_in_acked[e];                // R14
    end
    req_d     = '0;
    req_d[0]  = bus_ev && glb_en_q[pis_pkg::BIT_BUS];               // R23
    req_d[1]  = tick128 && glb_en_q[pis_pkg::BIT_T128];             // R4
    req_d[2]  = tick1024 && glb_en_q[pis_pkg::BIT_T1024];           // R3
    req_d[5:3] = ep_ev & ep_en_q[2:0];                              // R23
    req_d[6]  = spi_last_edge && glb_en_q[pis_pkg::BIT_SPI];        // R2
    req_d[7]  = cap_a_ev && glb_en_q[pis_pkg::BIT_CAPA];            // R1
    req_d[8]  = cap_b_ev && glb_en_q[pis_pkg::BIT_CAPB];            // R1
    req_d[9]  = gp_ev && glb_en_q[pis_pkg::BIT_GPIO];               // R23
    tcf_d     = spi_last_edge ? 1'b1 : transfer_complete_flag;      // R2
    req_stat  = {3'b000, gp_lock_q, bus_q == BUS_QUAL, ps2_mode,
                 transfer_complete_flag, bus_q != BUS_IDLE};
  end

  // Timer, detector, lockout and output registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q                  <= '0;
      ms_q                   <= '0;
      bus_q                  <= BUS_IDLE;
      bus_cnt_q              <= '0;
      gp_lock_q              <= 1'b0;
      gp_who_q               <= '0;
      irq_req                <= '0;
      transfer_complete_flag <= 1'b0;
      dev_addr_clear         <= 1'b0;
    end else begin
      pre_q                  <= pre_d;
      ms_q                   <= ms_d;
      bus_q                  <= bus_d;
      bus_cnt_q              <= bus_cnt_d;
      gp_lock_q              <= gp_lock_d;
      gp_who_q               <= gp_who_d;
      irq_req                <= req_d;
      transfer_complete_flag <= tcf_d;
      dev_addr_clear         <= (bus_d == BUS_QUAL);                // R10
    end
  end

endmodule // pis_top

// ### pis_top_tb_top.sv
// Testbench for the interrupt source block: register bus, events, pins, ticks.
// Assumes the checker is bound in and the CPU model counts the requests.
`timescale 1ns/100ps
module pis_top_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, cap_a_edge_en = '0, cap_b_edge_en = '0;
  logic [7:0]  port_zero_pins = 8'h00, port_one_pins = 8'hFF;
  logic        cap_a_pin = 1'b0, cap_b_pin = 1'b0, usb_dp = 1'b0, usb_dm = 1'b1;
  logic        ps2_data_pin = 1'b1, transfer_complete_flag, dev_addr_clear;
  logic [14:0] ev = '0;
  logic [10:0] irq_req;
  logic [7:0]  wo [4] = '{8'h03, 8'h80, 8'h03, 8'h00};
  logic [7:0]  gz [8] = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h04};
  logic [7:0]  go [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F};
  int          gn [8] = '{1, 1, 1, 1, 2, 2, 3, 3};
  int          n_errors = 0, check_count = 0, cyc = 0, n, t0, base [11];

  always #12.5 aclk = ~aclk;

  pis_top dut (.*, .spi_last_edge(ev[14]), .ep_data_written(ev[2:0]),
    .ep_ack_out_mode(ev[5:3]), .ep_nak_stall(ev[8:6]), .ep_in_acked(ev[11:9]),
    .ctl_setup_mode(ev[12]), .ctl_zlp_sent(ev[13]));
  pis_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req));
  ////////////////////////////////////////
  // Prints the verdict and ends the run.
  task conclude;
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  function logic [31:0] ad(input logic [7:0] i);
    return {22'h00_0000, i, 2'h0};
  endfunction
  task step(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task snap;
    base = cpu.cnt;
  endtask
  task cn(input string nm, input int b, input int inc);
    chk(nm, inc, cpu.cnt[b] - base[b]);
  endtask
  // Bus write: address and data offered together, each released once taken.
  task wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
    logic a, w, b;
    s_axi_awaddr <= ad(i);
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  // Bus read: data and response are taken at the edge that sees rvalid.
  task rd(input logic [7:0] i);
    logic a, r;
    s_axi_araddr <= ad(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      a = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // Pulses every endpoint and serial event except ev[9] (ep_in_acked[0]) once and looks at its request bit.
  task ev_pass(input logic p);
    int b;
    for (int k = 0; k < 15; k++) begin
      b = (k == 14) ? 6 : (k >= 12 ? 3 : 3 + k % 3);
      if (k != 9) begin
        ev[k] <= 1'b1;
        @(posedge aclk);
        ev <= '0;
        @(negedge aclk);
        chk("event_request", p, irq_req[b]);
        step(1);
      end
    end
  endtask
  ////////////////////////////////////////
  // The run takes about 87000 cycles; the ceiling adds a margin.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 99_000) begin
      n_errors++;
      conclude();
    end
  end
  // Main sequence.
  initial begin
    step(3);
    aresetn <= 1'b1;
    rd(pis_pkg::IDX_GLB_EN);
    chk("global_reset", 0, rd_v);
    rd(pis_pkg::IDX_EP_EN);
    chk("endpoint_reset", 0, rd_v);
    wr(pis_pkg::IDX_GLB_EN, 8'h07, 4'hF);
    ev_pass(1'b0);
    wr(pis_pkg::IDX_EP_EN, 8'hFF, 4'hF);
    rd(pis_pkg::IDX_EP_EN);
    chk("endpoint_bits", 32'h0000_0007, rd_v);
    wr(pis_pkg::IDX_EP_EN, 8'h00, 4'h0);
    rd(pis_pkg::IDX_EP_EN);
    chk("endpoint_strobe", 32'h0000_0007, rd_v);
    wr(pis_pkg::IDX_GLB_EN, 8'h0F, 4'hF);
    ev_pass(1'b1);
    chk("done_flag", 1, transfer_complete_flag);
    for (int i = 0; i < 4; i++) begin
      wr(8'(pis_pkg::IDX_P0_EN + i), wo[i], 4'hF);
      rd(8'(pis_pkg::IDX_P0_EN + i));
      chk("write_only_read", 0, rd_v);
    end
    rd(8'h3F);
    chk("unmapped_rresp", pis_pkg::RESP_SLVERR, rsp);
    wr(8'h3F, 8'h00, 4'hF);
    chk("unmapped_bresp", pis_pkg::RESP_SLVERR, rsp);
    wr(pis_pkg::IDX_GLB_EN, 8'h7F, 4'hF);
    cap_a_edge_en <= 2'h1;
    cap_b_edge_en <= 2'h2;
    step(10);
    snap();
    cap_a_pin <= 1'b1;
    cap_b_pin <= 1'b1;
    step(12);
    cn("capture_a_rise", 7, 1);
    cn("capture_b_rise", 8, 0);
    cap_a_pin <= 1'b0;
    cap_b_pin <= 1'b0;
    step(12);
    cn("capture_a_fall", 7, 1);
    cn("capture_b_fall", 8, 1);
    snap();
    for (int i = 0; i < 8; i++) begin
      port_zero_pins <= gz[i];
      port_one_pins <= go[i];
      step(10);
      cn("gpio_requests", 9, gn[i]);
    end
    wr(pis_pkg::IDX_USB_CTL, 8'h01, 4'hF);
    n = cpu.cnt[0];
    t0 = cpu.cyc;
    ps2_data_pin <= 1'b0;
    repeat (11000) if (cpu.cnt[0] == n) @(posedge aclk);
    chk("ps2_request", n + 1, cpu.cnt[0]);
    chk("ps2_delay", 1, cpu.last[0] - t0 >= 5100 && cpu.last[0] - t0 <= 10260);
    step(2);
    chk("ps2_addr_clear", 1, dev_addr_clear);
    ps2_data_pin <= 1'b1;
    step(5300);
    chk("addr_clear_end", 0, dev_addr_clear);
    wr(pis_pkg::IDX_USB_CTL, 8'h00, 4'hF);
    n = cpu.cnt[0];
    usb_dm <= 1'b0;
    step(11000);
    @(negedge aclk);
    chk("se0_no_request", n, cpu.cnt[0]);
    chk("se0_addr_clear", 1, dev_addr_clear);
    @(posedge aclk);
    usb_dm <= 1'b1;
    t0 = cpu.cyc;
    repeat (5300) if (cpu.cnt[0] == n) @(posedge aclk);
    chk("usb_request", n + 1, cpu.cnt[0]);
    chk("usb_late", 1, cpu.last[0] - t0 <= 5150);
    repeat (60000) if (cpu.cnt[2] < 2) @(posedge aclk);
    chk("short_tick_gap", 5120, cpu.gap[1]);
    chk("long_tick_gap", 40960, cpu.gap[2]);
    wr(pis_pkg::IDX_GLB_EN, 8'h79, 4'hF);
    snap();
    step(5200);
    cn("short_tick_off", 1, 0);
    cn("long_tick_off", 2, 0);
    conclude();
  end
endmodule // pis_top_tb_top
